// *** rtl/pfi_defines.svh ***
// register offsets, field positions, reset values and widths of the fault block
`ifndef PFI_DEFINES_SVH
`define PFI_DEFINES_SVH

`define PFI_ADDR_W 8
`define PFI_DATA_W 32
`define PFI_MINPER_W 16

// ==========================================
// register byte offsets
`define PFI_OFS_CTRL 8'h00
`define PFI_OFS_MINPER 8'h04
`define PFI_OFS_SENSE 8'h08
`define PFI_OFS_TRIG0 8'h0C
`define PFI_OFS_TRIG1 8'h10
`define PFI_OFS_FSTAT0 8'h14
`define PFI_OFS_FSTAT1 8'h18
`define PFI_OFS_FCLR0 8'h1C
`define PFI_OFS_FCLR1 8'h20
`define PFI_OFS_IRQ_EN 8'h24
`define PFI_OFS_IRQ_RAW 8'h28
`define PFI_OFS_IRQ_MSK 8'h2C

// ==========================================
// control register fields
`define PFI_CTRL_LATCH 0
`define PFI_CTRL_MINPER 1
`define PFI_CTRL_EXTSRC 2
`define PFI_CTRL_GEN_IRQ_EN 3

// ==========================================
// reset values
`define PFI_RST_CTRL 4'h0
`define PFI_RST_TRIG0 4'h1
`define PFI_RST_TRIG1 8'h00
`define PFI_RST_SENSE 4'h0
`define PFI_RST_MINPER 16'h0000

`endif

// *** rtl/pfi_pkg.sv ***
// types shared by the fault and interrupt block
package pfi_pkg;
	// six generator event sources, in status bit order
	typedef struct packed {
		logic irq_cmp_b_counting_down;
		logic irq_cmp_b_counting_up;
		logic irq_cmp_a_counting_down;
		logic irq_cmp_a_counting_up;
		logic irq_counter_at_load;
		logic irq_counter_at_zero;
	} pfi_irq_s;

	// raw fault trigger inputs of both groups
	typedef struct packed {
		logic [7:0] digital_cmp;
		logic [3:0] ext_fault;
	} pfi_trig_s;

	typedef enum logic [1:0] {
		PFI_IDLE,
		PFI_ACTIVE,
		PFI_STRETCH
	} pfi_state_e;
endpackage

// *** rtl/pfi_minper.sv ***
// minimum fault period stretcher
`timescale 1ns/1ps
`include "pfi_defines.svh"

module pfi_minper
	import pfi_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic enable_i,
	input wire logic [`PFI_MINPER_W-1:0] period_i,
	input wire logic fault_i,
	output logic fault_o
);
	logic [`PFI_MINPER_W-1:0] count;
	pfi_state_e state;

	// ==========================================
	// state and down counter
	// reload while the source is up so the stretch starts at release
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= PFI_IDLE;
			count <= '0;
		end else begin
			case (state)
				PFI_IDLE: begin
					if (fault_i) begin
						state <= PFI_ACTIVE;
						count <= period_i;
					end
				end
				PFI_ACTIVE: begin
					count <= period_i;
					if (!fault_i) begin
						if (enable_i && period_i > 16'h0001) begin
							state <= PFI_STRETCH;
							count <= period_i - 16'h0002;
						end else begin
							state <= PFI_IDLE;
						end
					end
				end
				PFI_STRETCH: begin
					if (fault_i) begin
						state <= PFI_ACTIVE;
						count <= period_i;
					end else if (count == '0) begin
						state <= PFI_IDLE;
					end else begin
						count <= count - 16'h0001;
					end
				end
				default: begin
					state <= PFI_IDLE;
				end
			endcase
		end
	end

	// held fault covers at least period cycles from first assertion;
	// the hold states count only while the option is on, so a plain
	// fault follows its source with no extra cycle
	always_comb begin
		fault_o = fault_i || (enable_i && (state == PFI_STRETCH ||
			(state == PFI_ACTIVE && period_i > 16'h0001)));
	end
endmodule

// *** rtl/pfi_fault_irq.sv ***
// fault qualification and interrupt logic of one pwm generator
`timescale 1ns/1ps
`include "pfi_defines.svh"

// Overview of operation
// - a fault stays asserted at least the programmed minimum number of cycles
// - stretching only applies while the minimum period option is set
// - each of four external fault inputs has its own active level
// - fault is the OR of enabled triggers after sense correction
// - group zero holds four fault pins, group one eight comparators
// - after reset only external fault input zero is a fault source
// - extended option selects the programmed triggers; software programs them
// - software reads back the trigger enables of each group
// - trigger status is live, or latched when latching is set
// - a status one means the trigger is active or latched active
// - writing one clears an interrupt status bit, zero leaves it
// - raw and masked status views, masked is raw AND enables
// - interrupt needs both generator enable and source enable
// - fault interrupt stays up for the whole stretched period
// - suppressed outputs go low during a fault unless level configured
module pfi_fault_irq
	import pfi_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [`PFI_ADDR_W-1:0] addr_i,
	input wire logic [`PFI_DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [`PFI_DATA_W-1:0] rdata_o,
	input wire pfi_trig_s trig_i,
	input wire pfi_irq_s event_i,
	input wire logic [7:0] pwm_i,
	output logic [7:0] pwm_o,
	output logic fault_o,
	output logic fault_irq_o,
	output logic irq_o
);
	// ==========================================
	// configuration registers
	logic latch_mode;
	logic min_fault_period_option;
	logic extended_fault_source_option;
	logic gen_irq_en;
	logic [`PFI_MINPER_W-1:0] min_period;
	logic [3:0] fault_input_active_low;
	logic [3:0] trig_sel_ext;
	logic [7:0] trig_sel_cmp;
	logic [7:0] suppress;
	logic [7:0] drive_high;
	pfi_irq_s irq_en;
	pfi_irq_s irq_raw;

	// ==========================================
	// fault trigger state
	logic [3:0] ext_adj;
	logic [3:0] ext_live;
	logic [7:0] cmp_live;
	logic [3:0] ext_latched;
	logic [7:0] cmp_latched;
	logic raw_fault;
	logic stretched;

	function automatic logic hit(input logic [`PFI_ADDR_W-1:0] ofs);
		hit = (addr_i == ofs);
	endfunction

	// sense correction for each external input
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sense
			// one selects fault_input_active_low, zero active high
			assign ext_adj[g] = trig_i.ext_fault[g] ^ fault_input_active_low[g];
		end
	endgenerate

	// pick the enabled triggers; legacy mode sees pin zero alone
	always_comb begin
		if (extended_fault_source_option) begin
			ext_live = ext_adj & trig_sel_ext;
			cmp_live = trig_i.digital_cmp & trig_sel_cmp;
		end else begin
			ext_live = {3'h0, ext_adj[0]};
			cmp_live = 8'h00;
		end
	end

	// latched copies include the live bits so nothing is lost on set
	always_comb begin
		if (latch_mode) begin
			raw_fault = |ext_latched | |cmp_latched | |ext_live | |cmp_live;
		end else begin
			raw_fault = |ext_live | |cmp_live;
		end
	end

	pfi_minper u_minper (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.enable_i(min_fault_period_option),
		.period_i(min_period),
		.fault_i(raw_fault),
		.fault_o(stretched)
	);

	// ==========================================
	// control register writes
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			{gen_irq_en, extended_fault_source_option,
				min_fault_period_option, latch_mode} <= `PFI_RST_CTRL;
			min_period <= `PFI_RST_MINPER;
			fault_input_active_low <= `PFI_RST_SENSE;
			suppress <= 8'h00;
			drive_high <= 8'h00;
		end else if (wr_i) begin
			if (hit(`PFI_OFS_CTRL)) begin
				latch_mode <= wdata_i[`PFI_CTRL_LATCH];
				min_fault_period_option <= wdata_i[`PFI_CTRL_MINPER];
				extended_fault_source_option <= wdata_i[`PFI_CTRL_EXTSRC];
				gen_irq_en <= wdata_i[`PFI_CTRL_GEN_IRQ_EN];
				suppress <= wdata_i[15:8];
				drive_high <= wdata_i[23:16];
			end
			if (hit(`PFI_OFS_MINPER)) begin
				min_period <= wdata_i[`PFI_MINPER_W-1:0];
			end
			if (hit(`PFI_OFS_SENSE)) begin
				fault_input_active_low <= wdata_i[3:0];
			end
		end
	end

	// trigger selections, reset to pin zero only
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			trig_sel_ext <= `PFI_RST_TRIG0;
			trig_sel_cmp <= `PFI_RST_TRIG1;
		end else if (wr_i) begin
			if (hit(`PFI_OFS_TRIG0)) begin
				trig_sel_ext <= wdata_i[3:0];
			end
			if (hit(`PFI_OFS_TRIG1)) begin
				trig_sel_cmp <= wdata_i[7:0];
			end
		end
	end

	// ==========================================
	// latched trigger status, set wins over a clear in the same cycle
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_latched <= 4'h0;
			cmp_latched <= 8'h00;
		end else if (!latch_mode) begin
			ext_latched <= 4'h0;
			cmp_latched <= 8'h00;
		end else begin
			if (wr_i && hit(`PFI_OFS_FCLR0)) begin
				ext_latched <= (ext_latched & ~wdata_i[3:0]) | ext_live;
			end else begin
				ext_latched <= ext_latched | ext_live;
			end
			if (wr_i && hit(`PFI_OFS_FCLR1)) begin
				cmp_latched <= (cmp_latched & ~wdata_i[7:0]) | cmp_live;
			end else begin
				cmp_latched <= cmp_latched | cmp_live;
			end
		end
	end

	// ==========================================
	// interrupt enable and sticky status
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_en <= '0;
		end else if (wr_i && hit(`PFI_OFS_IRQ_EN)) begin
			irq_en <= wdata_i[5:0];
		end
	end

	// an event landing in the clearing cycle stays set
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_raw <= '0;
		end else if (wr_i && hit(`PFI_OFS_IRQ_RAW)) begin
			irq_raw <= (irq_raw & ~wdata_i[5:0]) | event_i;
		end else begin
			irq_raw <= irq_raw | event_i;
		end
	end

	// ==========================================
	// outputs, all registered
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_o <= 1'b0;
			fault_o <= 1'b0;
			fault_irq_o <= 1'b0;
		end else begin
			irq_o <= gen_irq_en && |(irq_raw & irq_en);
			fault_o <= stretched;
			fault_irq_o <= stretched;
		end
	end

	// suppressed outputs take the chosen level, low by default
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pwm_o <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (stretched && suppress[i]) begin
					pwm_o[i] <= drive_high[i];
				end else begin
					pwm_o[i] <= pwm_i[i];
				end
			end
		end
	end

	// ==========================================
	// read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= '0;
		end else if (!rd_i) begin
			rdata_o <= '0;
		end else begin
			case (addr_i)
				`PFI_OFS_CTRL: rdata_o <= {8'h00, drive_high, suppress, 4'h0,
					gen_irq_en, extended_fault_source_option,
					min_fault_period_option, latch_mode};
				`PFI_OFS_MINPER: rdata_o <= {16'h0000, min_period};
				`PFI_OFS_SENSE: rdata_o <= {28'h0, fault_input_active_low};
				`PFI_OFS_TRIG0: rdata_o <= {28'h0, trig_sel_ext};
				`PFI_OFS_TRIG1: rdata_o <= {24'h0, trig_sel_cmp};
				`PFI_OFS_FSTAT0: rdata_o <= {28'h0,
					latch_mode ? ext_latched : ext_live};
				`PFI_OFS_FSTAT1: rdata_o <= {24'h0,
					latch_mode ? cmp_latched : cmp_live};
				`PFI_OFS_IRQ_EN: rdata_o <= {26'h0, irq_en};
				`PFI_OFS_IRQ_RAW: rdata_o <= {26'h0, irq_raw};
				`PFI_OFS_IRQ_MSK: rdata_o <= {26'h0, irq_raw & irq_en};
				default: rdata_o <= '0;
			endcase
		end
	end
endmodule

// *** verif/pfi_src_model.sv ***
// far side model: fault pins and comparator outputs
`timescale 1ns/1ps
module pfi_src_model
	import pfi_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic [3:0] pin_i,
	input wire logic [7:0] cmp_i,
	output pfi_trig_s trig_o
);
	// synchronous levels; the first edge settles them long before reset ends
	always @(posedge ref_clk_i) begin
		trig_o <= {cmp_i, pin_i};
	end
endmodule

// *** verif/pfi_fault_irq_chk.sv ***
// port checker of the fault and interrupt block
`timescale 1ns/1ps
module pfi_fault_irq_chk
	import pfi_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire pfi_trig_s trig_i,
	input wire pfi_irq_s event_i,
	input wire logic [7:0] pwm_i,
	input wire logic [7:0] pwm_o,
	input wire logic fault_o,
	input wire logic fault_irq_o,
	input wire logic irq_o
);
	logic [3:0] ctl;
	logic [3:0] sns;
	logic [3:0] t0;
	logic [7:0] t1;
	logic [15:0] per;
	logic [15:0] run;
	logic [1:0] age;
	logic src;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// ==========================================
	// shadow setup; age hides the cycles right after a write
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctl <= 4'h0;
			sns <= 4'h0;
			t0 <= 4'h1;
			t1 <= 8'h00;
			per <= 16'h0000;
			age <= 2'h0;
		end else begin
			age <= wr_i ? 2'h0 : age + {1'b0, age != 2'h3};
			if (wr_i && addr_i == 8'h00) ctl <= wdata_i[3:0];
			if (wr_i && addr_i == 8'h04) per <= wdata_i[15:0];
			if (wr_i && addr_i == 8'h08) sns <= wdata_i[3:0];
			if (wr_i && addr_i == 8'h0C) t0 <= wdata_i[3:0];
			if (wr_i && addr_i == 8'h10) t1 <= wdata_i[7:0];
		end
	end
	// length of the current fault run
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			run <= 16'h0000;
		else
			run <= fault_o ? run + 16'h0001 : 16'h0000;
	end
	// qualified source of the extended mode
	assign src = |((trig_i.ext_fault ^ sns) & t0) | |(trig_i.digital_cmp & t1);

	a_rdata_idle: assert property (
		!$past(rd_i) |-> rdata_o == 32'h0) else $error("read data not idle");
	a_legacy_src: assert property (
		age == 2'h3 && ctl == 4'h0
		|=> fault_o == $past(trig_i.ext_fault[0] ^ sns[0]))
		else $error("legacy fault source wrong");
	a_ext_or: assert property (
		age == 2'h3 && ctl[2:0] == 3'h4 |=> fault_o == $past(src))
		else $error("extended fault not the or of triggers");
	a_fault_stretch: assert property (
		age == 2'h3 && ctl[1] && per > 16'h1 && $fell(fault_o)
		|-> run >= per) else $error("fault shorter than minimum");
	a_fault_irq_same: assert property (
		fault_irq_o == fault_o) else $error("fault interrupt differs");
	a_pwm_pass: assert property (
		$past(reset_n_i) && !fault_o && !$past(fault_o)
		|-> pwm_o == $past(pwm_i)) else $error("pwm not passed through");
	a_irq_clear: assert property (
		wr_i && addr_i == 8'h28 && wdata_i[5:0] == 6'h3F && event_i == 6'h00
		##1 (event_i == 6'h00) [*3] |-> !irq_o) else $error("irq not cleared");
	a_irq_cause: assert property (
		$rose(irq_o) |-> $past(event_i, 2) != 6'h00 || $past(wr_i)
		|| $past(wr_i, 2) || $past(wr_i, 3)) else $error("irq without cause");
	c_stretch: cover property (ctl[1] && $fell(fault_o));
	c_ext: cover property (ctl[2] && $rose(fault_o));
	c_irq: cover property ($rose(irq_o));
endmodule

// *** verif/testbench.sv ***
// self-checking bench of the fault and interrupt block
`timescale 1ns/1ps
module testbench;
	import pfi_pkg::*;
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	pfi_trig_s trig_i;
	pfi_irq_s event_i = '0;
	logic [7:0] pwm_i = 8'hFF;
	logic [7:0] pwm_o;
	logic fault_o;
	logic fault_irq_o;
	logic irq_o;
	logic [3:0] pin = 4'h0;
	logic [7:0] cmp = 8'h00;
	int failures = 0;
	int checks_done = 0;
	int n;
	int c;
	always #2.5 ref_clk_i = ~ref_clk_i;
	pfi_src_model pfi_src_model_i(.ref_clk_i(ref_clk_i), .pin_i(pin),
		.cmp_i(cmp), .trig_o(trig_i));
	pfi_fault_irq pfi_fault_irq_i(.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_i(trig_i),
		.event_i(event_i), .pwm_i(pwm_i), .pwm_o(pwm_o), .fault_o(fault_o),
		.fault_irq_o(fault_irq_o), .irq_o(irq_o));
	// ==========================================
	// bus cycles, waits and comparison
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		chk($sformatf("reg %h", a), e, rdata_o);
	endtask
	task automatic wait_fault(input logic v);
		n = 0;
		while (fault_o !== v && n < 20) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk("fault", v, fault_o);
		if (fault_o !== v)
			report_and_stop();
	endtask
	task automatic pulse_count();
		@(posedge ref_clk_i);
		cmp <= 8'h80;
		@(posedge ref_clk_i);
		cmp <= 8'h00;
		c = 0;
		repeat (20) begin
			@(negedge ref_clk_i);
			c += (fault_o === 1'b0) ? 0 : 1;
		end
	endtask
	task automatic ev(input logic [5:0] b);
		@(posedge ref_clk_i);
		event_i <= b;
		@(posedge ref_clk_i);
		event_i <= '0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic s_legacy();
		rd(8'h0C, 32'h1);
		rd(8'hFC, 32'h0);
		@(posedge ref_clk_i);
		pin <= 4'h1;
		wait_fault(1'b1);
		rd(8'h14, 32'h1);
		@(posedge ref_clk_i);
		pin <= 4'h2;
		repeat (4) @(negedge ref_clk_i);
		wait_fault(1'b0);
	endtask
	task automatic s_ext();
		wr(8'h08, 32'h2);
		wr(8'h0C, 32'h2);
		wr(8'h10, 32'h80);
		wr(8'h00, 32'h00F0FF04);
		rd(8'h0C, 32'h2);
		rd(8'h10, 32'h80);
		@(posedge ref_clk_i);
		pin <= 4'h0;
		wait_fault(1'b1);
		@(negedge ref_clk_i);
		chk("pwm", 8'hF0, pwm_o);
		@(posedge ref_clk_i);
		pin <= 4'h2;
		cmp <= 8'h01;
		repeat (4) @(negedge ref_clk_i);
		wait_fault(1'b0);
	endtask
	task automatic s_minper();
		wr(8'h04, 32'h5);
		wr(8'h00, 32'h6);
		pulse_count();
		chk("stretch", 1'b1, c >= 5 && c <= 7);
		wr(8'h00, 32'h4);
		pulse_count();
		chk("plain", 32'h1, c);
		wr(8'h00, 32'h5);
		pulse_count();
		rd(8'h18, 32'h80);
		wr(8'h20, 32'h80);
		rd(8'h18, 32'h0);
	endtask
	task automatic s_irq();
		wr(8'h24, 32'h5);
		wr(8'h00, 32'hC);
		for (int i = 0; i < 6; i++)
			ev(6'h01 << i);
		wr(8'h28, 32'h0);
		rd(8'h28, 32'h3F);
		rd(8'h2C, 32'h5);
		chk("irq", 1'b1, irq_o);
		wr(8'h28, 32'h1);
		repeat (3) @(negedge ref_clk_i);
		chk("irq", 1'b1, irq_o);
		wr(8'h28, 32'h3F);
		repeat (3) @(negedge ref_clk_i);
		chk("irq", 1'b0, irq_o);
		wr(8'h00, 32'h4);
		ev(6'h01);
		repeat (3) @(negedge ref_clk_i);
		chk("irq", 1'b0, irq_o);
		rd(8'h2C, 32'h1);
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (20) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		s_legacy();
		s_ext();
		s_minper();
		s_irq();
		report_and_stop();
	end
endmodule

bind pfi_fault_irq pfi_fault_irq_chk pfi_fault_irq_chk_i(.ref_clk_i(ref_clk_i),
	.reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .trig_i(trig_i), .event_i(event_i),
	.pwm_i(pwm_i), .pwm_o(pwm_o), .fault_o(fault_o),
	.fault_irq_o(fault_irq_o), .irq_o(irq_o));
